/* hdl/prs_pkg.sv */
// Constants and types shared by the transceiver reset and start-up sequencer.
package prs_pkg;
   // Clock rate in kHz, 40 MHz crystal clock.
   localparam int unsigned CLK_KHZ = 40000;
   // Longest crystal settle time after power ramp, in ms.
   localparam int unsigned CRYSTAL_SETTLE_TIME_MS = 45;
   // Longest delay from stable crystal to release of the internal reset, in ms.
   localparam int unsigned POR_DELAY_MS = 40;
   // Longest core reset duration after reset release, in ms.
   localparam int unsigned CORE_RESET_DURATION_MS = 10;
   // Configuration deadline for the controller after reset complete, in ms.
   localparam int unsigned CONFIG_DEADLINE_MS = 500;
   // Cycle counts derived from the times above (longest times round down).
   localparam int unsigned POR_DELAY_CYC = POR_DELAY_MS * CLK_KHZ;
   localparam int unsigned CORE_RESET_CYC = CORE_RESET_DURATION_MS * CLK_KHZ;
   localparam int unsigned CONFIG_DEADLINE_CYC = CONFIG_DEADLINE_MS * CLK_KHZ;
   // Counter width, enough for the longest count.
   localparam int unsigned CNT_W = 25;
   // Width of the strap and bonding option words.
   localparam int unsigned STRAP_W = 8;
   // Reset values of the register groups.
   localparam logic [STRAP_W-1:0] STRAP_RST = 8'h00;
   localparam logic [STRAP_W-1:0] BOND_RST = 8'h00;
   localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
   // Position of the soft reset bit in management register 0.
   localparam int unsigned SOFT_RST_BIT = 15;
   // Address of management register 0 on page 0.
   localparam logic [4:0] MGMT_REG0 = 5'h00;
   localparam logic [7:0] MGMT_PAGE0 = 8'h00;
   // Start-up sequence states.
   typedef enum logic [3:0] {
      PRS_SETTLE,
      PRS_POR_WAIT,
      PRS_LATCH,
      PRS_LINK_TRAIN,
      PRS_ADDR_WAIT,
      PRS_STATUS_MSG,
      PRS_CONFIG,
      PRS_AUTONEG,
      PRS_POWER_DOWN
   } prs_state_e;
endpackage : prs_pkg

/* hdl/prs_sequencer.sv */
// Start-up ordering and reset distribution for a gigabit transceiver.
`timescale 1ns/1ps
// Overview of operation
// - Stable crystal, delay, release reset, latch straps.
// - Active-high master reset rst_i forces all defaults.
// - Train, await address, status, configure, negotiate.
// - Management bit 15 resets core only.
// - Link reset stops serdes, drops packet.
// - Link release clears FIFO unless wake switch.
// - In-band reset clears all but straps and wake filters.
// - Power-down pin also resets the core.
// - Each reset source clears its own groups.
// - Send reset-complete indication after core reset.
// - Bonding options load from memory or write.
// - Crystal stable within 45 ms.
// - Internal reset releases within 40 ms.
// - Core reset completes within 10 ms.
// - Soft reset clears page 0 only.
module prs_sequencer
   import prs_pkg::*;
#(
   parameter int unsigned POR_CYC = POR_DELAY_CYC,
   parameter int unsigned CORE_CYC = CORE_RESET_CYC,
   parameter int unsigned DEADLINE_CYC = CONFIG_DEADLINE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic crystal_stable_i,
   input wire logic [STRAP_W-1:0] strap_i,
   input wire logic serial_link_reset_pin_n_i,
   input wire logic lan_off_pin_n_i,
   input wire logic inband_reset_i,
   input wire logic wake_switch_i,
   input wire logic link_trained_i,
   input wire logic mgmt_addr_valid_i,
   input wire logic mgmt_wr_i,
   input wire logic [7:0] mgmt_page_i,
   input wire logic [4:0] mgmt_reg_i,
   input wire logic [15:0] mgmt_wdata_i,
   input wire logic config_done_i,
   input wire logic nvm_bond_load_i,
   input wire logic [STRAP_W-1:0] nvm_bond_i,
   input wire logic bond_wr_i,
   input wire logic [STRAP_W-1:0] bond_wdata_i,
   output logic por_n_o,
   output logic [STRAP_W-1:0] strap_o,
   output logic [STRAP_W-1:0] bond_o,
   output logic core_reset_o,
   output logic serdes_run_o,
   output logic drop_packet_o,
   output logic fifo_clear_o,
   output logic link_train_o,
   output logic status_msg_o,
   output logic reset_done_o,
   output logic autoneg_o,
   output logic config_late_o,
   output logic fuse_reload_o,
   output logic power_down_o,
   output logic [15:0] core_ctrl_o
);

   // Sequencer state and its next value.
   prs_state_e state_q, state_d;
   // Shared wait counter for the internal reset delay and the core reset timer.
   logic [CNT_W-1:0] cnt_q, cnt_d;
   // Internal reset level, low while held.
   logic por_n_q, por_n_d;
   // Latched straps and bonding options.
   logic [STRAP_W-1:0] strap_q, strap_d;
   logic [STRAP_W-1:0] bond_q, bond_d;
   // Core reset running, and reset-complete indication.
   logic core_rst_q, core_rst_d;
   logic done_q, done_d;
   // Serdes run flag, one-cycle event outputs, and the sticky late and power-down flags.
   logic serdes_q, serdes_d;
   logic drop_q, drop_d;
   logic fifo_clr_q, fifo_clr_d;
   logic fuse_q, fuse_d;
   logic status_q, status_d;
   logic late_q, late_d;
   logic pd_q, pd_d;
   // Core page 0 control word, the only core register kept here.
   logic [15:0] ctrl_q, ctrl_d;
   // Previous level of the link reset pin; resets to its idle high level, so no false edge.
   logic link_n_q;
   // Configuration deadline counter, separate so it runs alongside the steps.
   logic [CNT_W-1:0] dl_q, dl_d;
   logic train_q, train_d, aneg_q, aneg_d; // Registered state decodes for the outputs.

   // Decode of a page 0 register 0 write; used for soft reset and control.
   function automatic logic is_reg0(input logic [7:0] page, input logic [4:0] rg);
      is_reg0 = (page == MGMT_PAGE0) && (rg == MGMT_REG0);
   endfunction : is_reg0

   logic soft_rst, link_rise, link_fall; // Decoded request strobes.
   assign soft_rst = mgmt_wr_i && is_reg0(mgmt_page_i, mgmt_reg_i)
                     && mgmt_wdata_i[SOFT_RST_BIT];
   assign link_rise = serial_link_reset_pin_n_i && !link_n_q;
   assign link_fall = !serial_link_reset_pin_n_i && link_n_q;

   // Next-state logic for the start-up sequence and every reset source.
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      por_n_d = por_n_q;
      strap_d = strap_q;
      bond_d = bond_q;
      core_rst_d = core_rst_q;
      done_d = done_q;
      serdes_d = serdes_q;
      drop_d = 1'b0;
      fifo_clr_d = 1'b0;
      fuse_d = 1'b0;
      status_d = 1'b0;
      late_d = late_q;
      pd_d = pd_q;
      ctrl_d = ctrl_q;
      dl_d = dl_q;
      // Bonding options take either source; the controller write wins a tie.
      if (nvm_bond_load_i) begin
         bond_d = nvm_bond_i;
      end
      if (bond_wr_i) begin
         bond_d = bond_wdata_i;
      end
      // Ordinary control writes to page 0 register 0.
      if (mgmt_wr_i && is_reg0(mgmt_page_i, mgmt_reg_i) && !core_rst_q) begin
         ctrl_d = mgmt_wdata_i;
         ctrl_d[SOFT_RST_BIT] = 1'b0;
      end
      unique case (state_q)
         PRS_SETTLE: begin
            // Waits for the crystal; the internal reset stays low.
            cnt_d = '0;
            if (crystal_stable_i) begin
               state_d = PRS_POR_WAIT;
            end
         end
         PRS_POR_WAIT: begin
            // Bounded delay after the crystal settles.
            if (cnt_q >= CNT_W'(POR_CYC - 1)) begin
               por_n_d = 1'b1;
               state_d = PRS_LATCH;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         PRS_LATCH: begin
            // Straps are caught one clock after release, never under reset.
            strap_d = strap_i;
            core_rst_d = 1'b1;
            cnt_d = '0;
            state_d = PRS_LINK_TRAIN;
         end
         PRS_LINK_TRAIN: begin
            // Training runs the serdes, and only with the link reset pin deasserted.
            serdes_d = serial_link_reset_pin_n_i;
            if (serial_link_reset_pin_n_i && link_trained_i) begin
               state_d = PRS_ADDR_WAIT;
            end
         end
         PRS_ADDR_WAIT: begin
            if (mgmt_addr_valid_i && done_q) begin
               state_d = PRS_STATUS_MSG;
            end
         end
         PRS_STATUS_MSG: begin
            status_d = 1'b1;
            dl_d = '0;
            state_d = PRS_CONFIG;
         end
         PRS_CONFIG: begin
            // Flags a controller that misses its deadline; sticky until reset.
            if (config_done_i) begin
               state_d = PRS_AUTONEG;
            end else if (dl_q >= CNT_W'(DEADLINE_CYC - 1)) begin
               late_d = 1'b1;
            end else begin
               dl_d = dl_q + 1'b1;
            end
         end
         PRS_AUTONEG, PRS_POWER_DOWN: begin
            // Both hold; only the in-band message or the master reset brings the part out of power-down.
            state_d = state_q;
         end
         default: begin
            state_d = PRS_SETTLE;
         end
      endcase
      // Core reset timer counts independently of the sequence step.
      if (core_rst_q) begin
         if (cnt_q >= CNT_W'(CORE_CYC - 1)) begin
            core_rst_d = 1'b0;
            done_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
      // Link reset: stop serdes and drop any packet in flight.
      if (link_fall) begin
         serdes_d = 1'b0;
         drop_d = 1'b1;
      end
      if (link_rise) begin
         serdes_d = 1'b1;
         fifo_clr_d = !wake_switch_i;
      end
      // Soft reset restarts the core only; page 0 returns to defaults.
      if (soft_rst && por_n_q) begin
         core_rst_d = 1'b1;
         done_d = 1'b0;
         ctrl_d = CORE_CTRL_RST;
         cnt_d = '0;
      end
      // The power-down pin is also a core reset, and enters power-down.
      if (!lan_off_pin_n_i && por_n_q) begin
         core_rst_d = 1'b1;
         done_d = 1'b0;
         ctrl_d = CORE_CTRL_RST;
         cnt_d = '0;
         pd_d = 1'b1;
         state_d = PRS_POWER_DOWN;
      end
      // In-band reset: all but straps and wake filters, and leaves power-down.
      if (inband_reset_i && por_n_q) begin
         core_rst_d = 1'b1;
         done_d = 1'b0;
         ctrl_d = CORE_CTRL_RST;
         bond_d = BOND_RST;
         fuse_d = 1'b1;
         serdes_d = 1'b0;
         late_d = 1'b0;
         pd_d = 1'b0;
         cnt_d = '0;
         state_d = PRS_LINK_TRAIN;
      end
      train_d = (state_d == PRS_LINK_TRAIN);
      aneg_d = (state_d == PRS_AUTONEG);
   end

   // Registers; the asynchronous reset is the master reset of everything.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= PRS_SETTLE;
         cnt_q <= '0;
         por_n_q <= 1'b0;
         strap_q <= STRAP_RST;
         bond_q <= BOND_RST;
         core_rst_q <= 1'b0;
         done_q <= 1'b0;
         serdes_q <= 1'b0;
         drop_q <= 1'b0;
         fifo_clr_q <= 1'b0;
         fuse_q <= 1'b0;
         status_q <= 1'b0;
         late_q <= 1'b0;
         pd_q <= 1'b0;
         ctrl_q <= CORE_CTRL_RST;
         link_n_q <= 1'b1;
         dl_q <= '0;
         train_q <= 1'b0;
         aneg_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         por_n_q <= por_n_d;
         strap_q <= strap_d;
         bond_q <= bond_d;
         core_rst_q <= core_rst_d;
         done_q <= done_d;
         serdes_q <= serdes_d;
         drop_q <= drop_d;
         fifo_clr_q <= fifo_clr_d;
         fuse_q <= fuse_d;
         status_q <= status_d;
         late_q <= late_d;
         pd_q <= pd_d;
         ctrl_q <= ctrl_d;
         link_n_q <= serial_link_reset_pin_n_i;
         dl_q <= dl_d;
         train_q <= train_d;
         aneg_q <= aneg_d;
      end
   end

   assign por_n_o = por_n_q;
   assign strap_o = strap_q;
   assign bond_o = bond_q;
   assign core_reset_o = core_rst_q;
   assign serdes_run_o = serdes_q;
   assign drop_packet_o = drop_q;
   assign fifo_clear_o = fifo_clr_q;
   assign link_train_o = train_q;
   assign status_msg_o = status_q;
   assign reset_done_o = done_q;
   assign autoneg_o = aneg_q;
   assign config_late_o = late_q;
   assign fuse_reload_o = fuse_q;
   assign power_down_o = pd_q;
   assign core_ctrl_o = ctrl_q;

   // Checks on the sequence and the reset distribution.
   a_strap_after_por: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(por_n_q) |=> (strap_q == $past(strap_i, 1)))
      else $error("straps not latched after release");
   a_por_low_settle: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == PRS_SETTLE) |-> !por_n_q)
      else $error("internal reset released before settle");
   a_order_status: assert property (@(posedge clk_i) disable iff (rst_i)
      status_q |-> done_q && $past(state_q) == PRS_STATUS_MSG)
      else $error("status message out of order");
   a_soft_core: assert property (@(posedge clk_i) disable iff (rst_i)
      (soft_rst && por_n_q && !inband_reset_i) |=> core_rst_q && $stable(strap_q))
      else $error("soft reset effect wrong");
   a_link_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      link_fall |=> !serdes_q && drop_q)
      else $error("serdes not stopped");
   a_fifo_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (link_rise && !inband_reset_i) |=> fifo_clr_q == !$past(wake_switch_i))
      else $error("fifo clear wrong");
   a_inband_all: assert property (@(posedge clk_i) disable iff (rst_i)
      (inband_reset_i && por_n_q) |=> core_rst_q && fuse_q && !pd_q && !done_q)
      else $error("in-band reset incomplete");
   a_pin_core: assert property (@(posedge clk_i) disable iff (rst_i)
      (!lan_off_pin_n_i && por_n_q && !inband_reset_i) |=> core_rst_q && pd_q)
      else $error("power-down pin did not reset core");
   a_done_time: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(core_rst_q) |-> done_q)
      else $error("reset complete not raised");
   a_page_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      (soft_rst && por_n_q) |=> ctrl_q == CORE_CTRL_RST)
      else $error("page 0 not cleared");

   c_autoneg: cover property (@(posedge clk_i) disable iff (rst_i) $rose(autoneg_o));
   c_inband: cover property (@(posedge clk_i) disable iff (rst_i) inband_reset_i && done_q);
   c_wake: cover property (@(posedge clk_i) disable iff (rst_i) link_rise && wake_switch_i);

endmodule : prs_sequencer

/* verification/prs_ctrl_model.sv */
// Behavioural model of the LAN controller that faces the sequencer.
`timescale 1ns/1ps
module prs_ctrl_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_train_i,
   input wire logic status_msg_i,
   input wire logic reset_done_i,
   input wire logic [7:0] delay_i,
   output logic link_trained_o,
   output logic addr_valid_o,
   output logic config_done_o
);
   // Cycles left before configuration is reported; zero while idle.
   logic [7:0] wait_q;
   // Training ends one cycle after it starts, and the address is offered once out of reset.
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         link_trained_o <= 1'b0;
         addr_valid_o <= 1'b0;
         config_done_o <= 1'b0;
         wait_q <= 8'h00;
      end else begin
         link_trained_o <= link_train_i;
         addr_valid_o <= 1'b1;
         config_done_o <= 1'b0;
         // Configuring starts only once reset complete has been seen.
         if (status_msg_i && reset_done_i) begin
            wait_q <= delay_i;
         end else if (wait_q == 8'h01) begin
            config_done_o <= 1'b1;
            wait_q <= 8'h00;
         end else if (wait_q != 8'h00) begin
            wait_q <= wait_q - 8'h01;
         end
      end
   end
endmodule : prs_ctrl_model

/* verification/prs_sequencer_test.sv */
// Self-checking testbench for the start-up and reset sequencer.
`timescale 1ns/1ps
module prs_sequencer_test;
   import prs_pkg::*;
   logic clk_i, rst_i, crystal_stable_i, serial_link_reset_pin_n_i, lan_off_pin_n_i;
   logic inband_reset_i, wake_switch_i, link_trained_i, mgmt_addr_valid_i, mgmt_wr_i;
   logic [7:0] mgmt_page_i, strap_i, nvm_bond_i, bond_wdata_i, delay;
   logic [4:0] mgmt_reg_i;
   logic [15:0] mgmt_wdata_i, core_ctrl_o;
   logic config_done_i, nvm_bond_load_i, bond_wr_i, por_n_o, core_reset_o, serdes_run_o;
   logic [7:0] strap_o, bond_o;
   logic drop_packet_o, fifo_clear_o, link_train_o, status_msg_o, reset_done_o, autoneg_o;
   logic config_late_o, fuse_reload_o, power_down_o;
   // Pulse counters, since a one-cycle pulse is easy to miss by polling.
   int n_drop, n_fifo, n_status, n_fuse, num_errors, compares, i;
   prs_sequencer #(.POR_CYC(4), .CORE_CYC(8), .DEADLINE_CYC(20)) dut (.clk_i(clk_i),
      .rst_i(rst_i), .crystal_stable_i(crystal_stable_i), .strap_i(strap_i),
      .serial_link_reset_pin_n_i(serial_link_reset_pin_n_i),
      .lan_off_pin_n_i(lan_off_pin_n_i),
      .inband_reset_i(inband_reset_i), .wake_switch_i(wake_switch_i),
      .link_trained_i(link_trained_i), .mgmt_addr_valid_i(mgmt_addr_valid_i),
      .mgmt_wr_i(mgmt_wr_i), .mgmt_page_i(mgmt_page_i), .mgmt_reg_i(mgmt_reg_i),
      .mgmt_wdata_i(mgmt_wdata_i), .config_done_i(config_done_i),
      .nvm_bond_load_i(nvm_bond_load_i), .nvm_bond_i(nvm_bond_i), .bond_wr_i(bond_wr_i),
      .bond_wdata_i(bond_wdata_i), .por_n_o(por_n_o), .strap_o(strap_o), .bond_o(bond_o),
      .core_reset_o(core_reset_o), .serdes_run_o(serdes_run_o),
      .drop_packet_o(drop_packet_o), .fifo_clear_o(fifo_clear_o),
      .link_train_o(link_train_o), .status_msg_o(status_msg_o),
      .reset_done_o(reset_done_o), .autoneg_o(autoneg_o), .config_late_o(config_late_o),
      .fuse_reload_o(fuse_reload_o), .power_down_o(power_down_o),
      .core_ctrl_o(core_ctrl_o));
   prs_ctrl_model partner (.clk_i(clk_i), .rst_i(rst_i), .link_train_i(link_train_o),
      .status_msg_i(status_msg_o), .reset_done_i(reset_done_o), .delay_i(delay),
      .link_trained_o(link_trained_i), .addr_valid_o(mgmt_addr_valid_i),
      .config_done_o(config_done_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Count every pulse the design emits.
   always @(posedge clk_i) begin
      n_drop += (drop_packet_o === 1'b1);
      n_fifo += (fifo_clear_o === 1'b1);
      n_status += (status_msg_o === 1'b1);
      n_fuse += (fuse_reload_o === 1'b1);
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Waits n edges and a little more, so the edge's updates have landed.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   task automatic mgmt_write(input logic [7:0] page, input logic [15:0] data);
      @(posedge clk_i);
      mgmt_wr_i <= 1'b1;
      mgmt_page_i <= page;
      mgmt_reg_i <= MGMT_REG0;
      mgmt_wdata_i <= data;
      @(posedge clk_i);
      mgmt_wr_i <= 1'b0;
      #1;
   endtask : mgmt_write
   task automatic t_power_up;
      tick(3);
      chk("por_n", por_n_o, 0);
      chk("strap", strap_o, 0);
      crystal_stable_i <= 1'b1;
      for (i = 0; i < 10 && por_n_o !== 1'b1; i++) tick(1);
      chk("por_n", por_n_o, 1);
      tick(1);
      strap_i <= 8'h5A;
      chk("strap", strap_o, 8'hA5);
      for (i = 0; i < 80 && autoneg_o !== 1'b1; i++) tick(1);
      chk("autoneg", autoneg_o, 1);
      chk("serdes", serdes_run_o, 1);
      chk("status", n_status, 1);
      chk("done", reset_done_o, 1);
      chk("late", config_late_o, 0);
      chk("strap", strap_o, 8'hA5);
   endtask : t_power_up
   task automatic t_bond;
      @(posedge clk_i);
      nvm_bond_load_i <= 1'b1;
      nvm_bond_i <= 8'h11;
      tick(1);
      nvm_bond_i <= 8'h22;
      bond_wr_i <= 1'b1;
      bond_wdata_i <= 8'h33;
      tick(1);
      nvm_bond_load_i <= 1'b0;
      bond_wr_i <= 1'b0;
      chk("bond", bond_o, 8'h33);
   endtask : t_bond
   task automatic t_soft_reset;
      mgmt_write(MGMT_PAGE0, 16'h0100);
      tick(1);
      chk("ctrl", core_ctrl_o, 16'h0100);
      mgmt_write(8'h01, 16'h8000);
      chk("core_rst", core_reset_o, 0);
      mgmt_write(MGMT_PAGE0, 16'h8100);
      chk("core_rst", core_reset_o, 1);
      chk("done", reset_done_o, 0);
      chk("ctrl", core_ctrl_o, 0);
      chk("strap", strap_o, 8'hA5);
      chk("bond", bond_o, 8'h33);
      for (i = 0; i < 12 && reset_done_o !== 1'b1; i++) tick(1);
      chk("done", reset_done_o, 1);
   endtask : t_soft_reset
   task automatic t_link_reset;
      @(posedge clk_i);
      serial_link_reset_pin_n_i <= 1'b0;
      tick(3);
      chk("serdes", serdes_run_o, 0);
      chk("drop", n_drop, 1);
      chk("done", reset_done_o, 1);
      wake_switch_i <= 1'b1;
      serial_link_reset_pin_n_i <= 1'b1;
      tick(3);
      chk("fifo", n_fifo, 0);
      wake_switch_i <= 1'b0;
      serial_link_reset_pin_n_i <= 1'b0;
      tick(2);
      serial_link_reset_pin_n_i <= 1'b1;
      tick(3);
      chk("fifo", n_fifo, 1);
   endtask : t_link_reset
   task automatic t_power_down;
      delay <= 8'd40;
      lan_off_pin_n_i <= 1'b0;
      tick(3);
      chk("pdown", power_down_o, 1);
      chk("core_rst", core_reset_o, 1);
      lan_off_pin_n_i <= 1'b1;
      tick(2);
      chk("pdown", power_down_o, 1);
      inband_reset_i <= 1'b1;
      tick(1);
      inband_reset_i <= 1'b0;
      tick(2);
      chk("pdown", power_down_o, 0);
      chk("fuse", n_fuse, 1);
      chk("strap", strap_o, 8'hA5);
      for (i = 0; i < 100 && config_late_o !== 1'b1; i++) tick(1);
      chk("late", config_late_o, 1);
   endtask : t_power_down
   task automatic t_master_reset;
      rst_i <= 1'b1;
      tick(2);
      chk("strap", strap_o, 0);
      chk("bond", bond_o, 0);
      chk("late", config_late_o, 0);
      rst_i <= 1'b0;
      // Early edges after release: still held, no false link edge pulse.
      tick(3);
      chk("por_n", por_n_o, 0);
      chk("serdes", serdes_run_o, 0);
      chk("fifo", n_fifo, 1);
   endtask : t_master_reset
   task automatic wrap_up;
      $display("Comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up
   // The run needs about a hundred cycles; five thousand means a hang.
   initial begin
      repeat (5000) @(posedge clk_i);
      num_errors++;
      wrap_up();
   end
   initial begin
      {rst_i, serial_link_reset_pin_n_i, lan_off_pin_n_i} = 3'b111;
      {crystal_stable_i, inband_reset_i, wake_switch_i, mgmt_wr_i} = 4'h0;
      {nvm_bond_load_i, bond_wr_i} = 2'b00;
      {mgmt_page_i, nvm_bond_i, bond_wdata_i} = 24'h000000;
      {mgmt_reg_i, mgmt_wdata_i} = 21'h000000;
      strap_i = 8'hA5;
      delay = 8'd5;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_power_up();
      t_bond();
      t_soft_reset();
      t_link_reset();
      t_power_down();
      t_master_reset();
      wrap_up();
   end
endmodule : prs_sequencer_test
